// ### core/led_pwm_pkg.sv
package led_pwm_pkg;
  localparam int DRIVER_COUNT = 8;
  localparam int PERIOD_STEPS = 512;
  localparam int STEP_WIDTH = 9;
  localparam int VALUE_WIDTH = 8;
  localparam logic [7:0] BYPASS_REQUEST_CODE = 8'h40;
  localparam logic [VALUE_WIDTH-1:0] PRESCALER_RESET = 8'h00;
  localparam logic [VALUE_WIDTH-1:0] DUTY_RESET = 8'h80;
  localparam logic [STEP_WIDTH-1:0] STEP_ONE = 9'h001;
  localparam logic [VALUE_WIDTH-1:0] PRESCALE_ONE = 8'h01;
  localparam logic [VALUE_WIDTH-1:0] DUTY_SCALE_SHIFT = 8'h01;

  typedef enum logic [1:0] {
    DRIVE_ON = 2'b00,
    DRIVE_OFF = 2'b01,
    DRIVE_RATE0 = 2'b10,
    DRIVE_RATE1 = 2'b11
  } drive_sel_t;

  typedef struct packed {
    logic [VALUE_WIDTH-1:0] frequency_prescaler_zero;
    logic [VALUE_WIDTH-1:0] frequency_prescaler_one;
    logic [VALUE_WIDTH-1:0] duty_cycle_setting_zero;
    logic [VALUE_WIDTH-1:0] duty_cycle_setting_one;
  } pwm_cfg_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_REQUESTED = 2'b01,
    MODE_BYPASS = 2'b10
  } clk_mode_t;
endpackage

// ### core/pwm_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_rate_gen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic [led_pwm_pkg::VALUE_WIDTH-1:0] prescale,
  input wire logic [led_pwm_pkg::VALUE_WIDTH-1:0] duty,
  output logic pwmOn,
  output logic periodEnd
);
  logic [led_pwm_pkg::VALUE_WIDTH-1:0] preCount;
  logic [led_pwm_pkg::STEP_WIDTH-1:0] step;
  logic stepAdvance;
  logic [led_pwm_pkg::STEP_WIDTH-1:0] dutyStep;

  assign stepAdvance = tick && (preCount >= prescale);
  assign dutyStep = {duty, 1'b0};
  assign periodEnd = stepAdvance && (step == led_pwm_pkg::STEP_WIDTH'(led_pwm_pkg::PERIOD_STEPS - 1));

  // Each tick passes prescale+1 times before the 512-step counter moves
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      preCount <= '0;
    end else if (tick) begin
      preCount <= stepAdvance ? '0 : preCount + led_pwm_pkg::PRESCALE_ONE; // R1
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step <= '0;
    end else if (stepAdvance) begin
      step <= step + led_pwm_pkg::STEP_ONE; // R1
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwmOn <= 1'b0;
    end else begin
      pwmOn <= (step < dutyStep);
    end
  end

  a_period_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R1
    periodEnd |=> step == '0) else $error("step counter did not wrap");
  a_prescale_hold: assert property (@(posedge clk) disable iff (sys_rst) // R1
    !stepAdvance |=> $stable(step)) else $error("step moved without a prescaled tick");
endmodule
`default_nettype wire

// ### core/led_pwm_external_clock_bypass.sv
// Notes on behaviour
// R1: In bypass, driver period is 512*(prescaler+1) external clock cycles.
// R2: After reset the block runs normal mode on its internal tick.
// R3: In normal mode address match and all programming writes are accepted.
// R4: Host issues bypass request first, then raises clock_source_select.
// R5: For accesses host drops select, transfers, then re-requests bypass.
// R6: Host withholds the external clock while back in normal mode.
// R7: Drivers not used for LEDs act as open-drain general-purpose bits.
// R8: Bypass request is a 0x40 control write followed by STOP.
// R9: While bypassed the device ignores addressing.
// R10: Drivers zero and one are not outputs while bypass is in use.
`timescale 1ns/1ps
`default_nettype none
module led_pwm_external_clock_bypass (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic internalTick,
  input wire logic clock_source_select,
  input wire logic lowest_address_pin,
  input wire logic addressMatch,
  input wire logic cfgWrite,
  input wire led_pwm_pkg::pwm_cfg_t cfgIn,
  input wire logic selWrite,
  input wire logic [2*led_pwm_pkg::DRIVER_COUNT-1:0] selIn,
  input wire logic controlWrite,
  input wire logic [7:0] controlData,
  input wire logic stopSeen,
  input wire logic [led_pwm_pkg::DRIVER_COUNT-1:0] pinIn,
  output logic addressAck,
  output logic bypassActive,
  output led_pwm_pkg::pwm_cfg_t cfgOut,
  output logic [led_pwm_pkg::DRIVER_COUNT-1:0] inputLevel,
  output logic [led_pwm_pkg::DRIVER_COUNT-1:0] driverOut,
  output logic [led_pwm_pkg::DRIVER_COUNT-1:0] driverOe
);
  led_pwm_pkg::clk_mode_t mode;
  led_pwm_pkg::pwm_cfg_t cfg;
  logic [2*led_pwm_pkg::DRIVER_COUNT-1:0] sel;
  logic selSync1, selSync2, extSync1, extSync2, extPrev;
  logic [led_pwm_pkg::DRIVER_COUNT-1:0] pinSync1, pinSync2;
  logic requestArmed;
  logic tick;
  logic rate0, rate1;
  logic [led_pwm_pkg::DRIVER_COUNT-1:0] sinkOn;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selSync1 <= 1'b0;
      selSync2 <= 1'b0;
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev <= 1'b0;
      pinSync1 <= '0;
      pinSync2 <= '0;
    end else begin
      selSync1 <= clock_source_select;
      selSync2 <= selSync1;
      extSync1 <= lowest_address_pin;
      extSync2 <= extSync1;
      extPrev <= extSync2;
      pinSync1 <= pinIn;
      pinSync2 <= pinSync1;
    end
  end

  // Control write of the request code arms bypass; STOP completes the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      requestArmed <= 1'b0;
    end else if (mode != led_pwm_pkg::MODE_NORMAL) begin
      requestArmed <= 1'b0;
    end else if (addressMatch && controlWrite) begin
      requestArmed <= (controlData == led_pwm_pkg::BYPASS_REQUEST_CODE); // R8
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= led_pwm_pkg::MODE_NORMAL; // R2
    end else begin
      case (mode)
        led_pwm_pkg::MODE_NORMAL: begin
          if (requestArmed && stopSeen) begin
            mode <= led_pwm_pkg::MODE_REQUESTED; // R8
          end
        end
        led_pwm_pkg::MODE_REQUESTED: begin
          if (selSync2) begin
            mode <= led_pwm_pkg::MODE_BYPASS; // R4
          end
        end
        led_pwm_pkg::MODE_BYPASS: begin
          if (!selSync2) begin
            mode <= led_pwm_pkg::MODE_NORMAL; // R5
          end
        end
        default: begin
          mode <= led_pwm_pkg::MODE_NORMAL;
        end
      endcase
    end
  end

  assign bypassActive = (mode == led_pwm_pkg::MODE_BYPASS);
  assign addressAck = addressMatch && !bypassActive; // R9 R3
  // Rising edges of the external clock replace the internal tick
  assign tick = bypassActive ? (extSync2 && !extPrev) : internalTick; // R1

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= '{led_pwm_pkg::PRESCALER_RESET, led_pwm_pkg::PRESCALER_RESET,
               led_pwm_pkg::DUTY_RESET, led_pwm_pkg::DUTY_RESET};
    end else if (addressAck && cfgWrite) begin
      cfg <= cfgIn; // R3
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel <= {led_pwm_pkg::DRIVER_COUNT{led_pwm_pkg::DRIVE_OFF}};
    end else if (addressAck && selWrite) begin
      sel <= selIn; // R3
    end
  end

  assign cfgOut = cfg;

  pwm_rate_gen rateZero (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .prescale(cfg.frequency_prescaler_zero),
    .duty(cfg.duty_cycle_setting_zero),
    .pwmOn(rate0),
    .periodEnd()
  );

  pwm_rate_gen rateOne (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .prescale(cfg.frequency_prescaler_one),
    .duty(cfg.duty_cycle_setting_one),
    .pwmOn(rate1),
    .periodEnd()
  );

  // Two-bit selection field of one driver
  function automatic led_pwm_pkg::drive_sel_t selOf(
    input logic [2*led_pwm_pkg::DRIVER_COUNT-1:0] fields, input int idx);
    return led_pwm_pkg::drive_sel_t'(fields[2*idx +: 2]);
  endfunction

  genvar i;
  generate
    for (i = 0; i < led_pwm_pkg::DRIVER_COUNT; i++) begin : g_drv
      always_comb begin
        case (selOf(sel, i))
          led_pwm_pkg::DRIVE_ON: sinkOn[i] = 1'b1;
          led_pwm_pkg::DRIVE_RATE0: sinkOn[i] = rate0;
          led_pwm_pkg::DRIVE_RATE1: sinkOn[i] = rate1;
          default: sinkOn[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Open drain: pin only pulled low; drivers 0 and 1 released in bypass
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      driverOe <= '0;
    end else begin
      driverOe <= sinkOn & ~({{(led_pwm_pkg::DRIVER_COUNT-2){1'b0}}, 2'b11}
        & {led_pwm_pkg::DRIVER_COUNT{bypassActive}}); // R7 R10
    end
  end

  assign driverOut = '0; // R7
  assign inputLevel = pinSync2; // R7

  // Bypass entry is a request write, then STOP, then the synchronised select
  sequence s_request_write;
    mode == led_pwm_pkg::MODE_NORMAL && addressMatch && controlWrite && !stopSeen
      && controlData == led_pwm_pkg::BYPASS_REQUEST_CODE;
  endsequence

  sequence s_request_stop;
    stopSeen && !controlWrite;
  endsequence

  sequence s_select_seen;
    mode == led_pwm_pkg::MODE_REQUESTED && selSync2;
  endsequence

  a_request_taken: assert property (@(posedge clk) disable iff (sys_rst) // R8
    s_request_write ##1 s_request_stop |=> mode == led_pwm_pkg::MODE_REQUESTED)
    else $error("bypass request sequence not taken");
  a_select_entry: assert property (@(posedge clk) disable iff (sys_rst) // R4
    s_select_seen |=> bypassActive) else $error("select did not enter bypass");
  a_bypass_needs_req: assert property (@(posedge clk) disable iff (sys_rst) // R4
    $rose(bypassActive) |-> $past(mode) == led_pwm_pkg::MODE_REQUESTED) else $error("bypass without request");
  a_leave_bypass: assert property (@(posedge clk) disable iff (sys_rst) // R5
    bypassActive && !selSync2 |=> !bypassActive) else $error("bypass not left");
  a_ack_blocked: assert property (@(posedge clk) disable iff (sys_rst) // R9
    bypassActive && addressMatch |=> $stable(cfg) && $stable(sel)) else $error("addressed access taken in bypass");
  a_low_drivers_off: assert property (@(posedge clk) disable iff (sys_rst) // R10
    bypassActive ##1 bypassActive |-> driverOe[1:0] == 2'b00) else $error("low drivers active in bypass");
  a_write_normal: assert property (@(posedge clk) disable iff (sys_rst) // R3
    addressMatch && cfgWrite && !bypassActive |=> cfg == $past(cfgIn)) else $error("write lost");
  a_sel_write: assert property (@(posedge clk) disable iff (sys_rst) // R3
    addressMatch && selWrite && !bypassActive |=> sel == $past(selIn)) else $error("selection write lost");
  a_no_write_bypass: assert property (@(posedge clk) disable iff (sys_rst) // R9
    bypassActive && $past(bypassActive) |=> $stable(cfg)) else $error("config changed in bypass");
  a_request_stop: assert property (@(posedge clk) disable iff (sys_rst) // R8
    mode == led_pwm_pkg::MODE_NORMAL && requestArmed && stopSeen |=> mode == led_pwm_pkg::MODE_REQUESTED)
    else $error("request not taken");
  a_drain_only: assert property (@(posedge clk) disable iff (sys_rst) // R7
    (driverOe & ~$past(sinkOn)) == '0 && driverOut == '0) else $error("driver sinks without selection");

  // Each driver follows its own selection one clock later, except drivers 0 and 1 while bypassed
  generate
    for (i = 0; i < led_pwm_pkg::DRIVER_COUNT; i++) begin : g_chk
      a_off_released: assert property (@(posedge clk) disable iff (sys_rst) // R7
        selOf(sel, i) == led_pwm_pkg::DRIVE_OFF |=> !driverOe[i]) else $error("released driver pulls low");
      a_on_sinks: assert property (@(posedge clk) disable iff (sys_rst) // R7 R10
        selOf(sel, i) == led_pwm_pkg::DRIVE_ON && (i > 1 || !bypassActive) |=> driverOe[i])
        else $error("driver set on does not sink");
    end
  endgenerate
endmodule
`default_nettype wire

// ### sim/host_clock_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_clock_model (
  input wire logic enable,
  output logic extClk
);
  // External time base, held low while enable is low
  initial extClk = 1'b0;
  always begin
    #20;
    extClk = enable ? ~extClk : 1'b0;
  end
endmodule
`default_nettype wire

// ### sim/led_pwm_external_clock_bypass_tb.sv
`timescale 1ns/1ps
`default_nettype none
module led_pwm_external_clock_bypass_tb;
  typedef struct {int id; logic [31:0] exp;} note_t;
  logic clk = 0, sys_rst = 1, internalTick = 0, sel = 0, extEn = 0, extClk;
  logic addressMatch = 0, cfgWrite = 0, selWrite = 0, controlWrite = 0, stopSeen = 0;
  logic addressAck, bypassActive;
  led_pwm_pkg::pwm_cfg_t cfgIn = '0, cfgOut, cfgNow;
  logic [15:0] selIn = '0;
  logic [7:0] controlData = '0, pinIn = '0, inputLevel, driverOut, driverOe;
  int errors = 0, comparisons = 0, cycles = 0, edges = 0, measured = 0;
  integer seed = 32'hf5be;
  string names[8] = '{"bypassActive", "addressAck", "cfgOut", "driverOe4", "inputLevel", "driverOut", "period",
    "driverOe10"};
  note_t q[$];
  note_t n;
  always #2 clk = ~clk;
  host_clock_model host_clock_model_inst (.enable(extEn), .extClk(extClk));
  led_pwm_external_clock_bypass led_pwm_external_clock_bypass_inst (.clk(clk), .sys_rst(sys_rst),
    .internalTick(internalTick), .clock_source_select(sel), .lowest_address_pin(extClk),
    .addressMatch(addressMatch), .cfgWrite(cfgWrite), .cfgIn(cfgIn), .selWrite(selWrite), .selIn(selIn),
    .controlWrite(controlWrite), .controlData(controlData), .stopSeen(stopSeen), .pinIn(pinIn),
    .addressAck(addressAck), .bypassActive(bypassActive), .cfgOut(cfgOut), .inputLevel(inputLevel),
    .driverOut(driverOut), .driverOe(driverOe));
  always @(negedge clk) internalTick <= (cycles % 4 == 0);
  always @(posedge extClk) edges++;
  task automatic results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      results();
    end
  end
  function automatic logic [31:0] seenOf(input int id);
    case (id)
      0: return {31'h0, bypassActive};
      1: return {31'h0, addressAck};
      2: return cfgOut;
      3: return {31'h0, driverOe[4]};
      4: return {24'h0, inputLevel};
      5: return {24'h0, driverOut};
      6: return 32'(measured);
      default: return {30'h0, driverOe[1:0]};
    endcase
  endfunction
  task automatic check(input int id, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", names[id], exp, seen);
    end
  endtask
  // Watcher: compares the oldest expectation with what the outputs show
  always @(posedge clk) begin
    if (q.size() > 0) begin
      n = q.pop_front();
      check(n.id, seenOf(n.id), n.exp);
    end
  end
  task automatic note(input int id, input logic [31:0] exp);
    q.push_back('{id, exp});
    wait (q.size() == 0);
  endtask
  task automatic write(input logic [31:0] v, input logic ack);
    @(negedge clk);
    addressMatch = 1;
    cfgWrite = 1;
    cfgIn = v;
    note(1, {31'h0, ack});
    @(negedge clk);
    addressMatch = 0;
    cfgWrite = 0;
  endtask
  task automatic enter_bypass;
    @(negedge clk);
    addressMatch = 1;
    controlWrite = 1;
    controlData = 8'h40;
    @(negedge clk);
    addressMatch = 0;
    controlWrite = 0;
    stopSeen = 1;
    @(negedge clk);
    stopSeen = 0;
    sel = 1;
    extEn = 1;
    repeat (8) @(negedge clk);
    note(0, 1);
  endtask
  task automatic period(input int b, input int exp);
    int start;
    @(posedge driverOe[b]);
    start = edges;
    @(posedge driverOe[b]);
    measured = edges - start;
    @(negedge clk);
    note(6, exp);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    note(0, 0);
    note(2, 32'h00008080);
    cfgNow = $random(seed);
    write(cfgNow, 1);
    note(2, cfgNow);
    @(negedge clk);
    addressMatch = 1;
    selWrite = 1;
    selIn = 16'h54e4;
    @(negedge clk);
    addressMatch = 0;
    selWrite = 0;
    @(negedge clk);
    note(3, 1);
    note(7, 1);
    @(negedge clk);
    pinIn = 8'($random(seed));
    repeat (4) @(negedge clk);
    note(4, {24'h0, pinIn});
    note(5, 0);
    write(32'h00018080, 1);
    note(2, 32'h00018080);
    enter_bypass();
    write($random(seed), 0);
    note(2, 32'h00018080);
    note(7, 0);
    period(2, 512);
    period(3, 1024);
    @(negedge clk);
    sel = 0;
    extEn = 0;
    repeat (8) @(negedge clk);
    note(0, 0);
    write(cfgNow, 1);
    note(2, cfgNow);
    enter_bypass();
    @(negedge clk);
    sys_rst = 1;
    extEn = 0;
    repeat (3) @(negedge clk);
    sys_rst = 0;
    note(0, 0);
    note(2, 32'h00008080);
    repeat (8) @(negedge clk);
    note(0, 0);
    @(negedge clk);
    sel = 0;
    results();
  end
endmodule
`default_nettype wire
